// File: shared/scp_params.svh
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// ****************************************************************
// Register offsets and field positions
// ****************************************************************
`define SCP_ADDR_W 2
`define SCP_OFF_PRESCALE 2'h0
`define SCP_OFF_TRIM 2'h1
`define SCP_OFF_STATUS 2'h2
`define SCP_PRESCALE_CE_BIT 7
`define SCP_TRIM_RANGE_BIT 7
`define SCP_CE_WRITE_VALUE 8'h80

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define SCP_DIV_SEL_DIV8 4'h3
`define SCP_DIV_SEL_DIV1 4'h0
`define SCP_DIV_SEL_MAX 4'h8
`define SCP_CE_WINDOW 3'h4

// ****************************************************************
// Timing counts
// ****************************************************************
`define SCP_SYS_CLK_PERIOD_NS 50
`define SCP_DELAY_SHORT_MS 4
`define SCP_DELAY_LONG_MS 64
`define SCP_NS_PER_MS 1000000
`define SCP_RESET_FIXED_CK 22'h00000E
`define SCP_START_258_CK 22'h000102
`define SCP_START_1K_CK 22'h000400
`define SCP_START_16K_CK 16384
`define SCP_START_RC_CK 22'h000006

`endif

// File: shared/scp_pkg.sv
package scp_pkg;

	typedef enum logic [1:0] {
		ST_STARTUP,
		ST_RUN,
		ST_POWER_DOWN
	} scp_state_t;

	typedef struct packed {
		scp_state_t state;
		logic [21:0] start_cnt;
		logic [3:0] div_sel;
		logic [3:0] new_sel;
		logic pend;
		logic change_en;
		logic [2:0] ce_timer;
		logic [7:0] div_cnt;
		logic [7:0] trim;
		logic [7:0] rdata;
		logic sys_tick;
		logic pin_level;
		logic pin_oe;
		logic running;
	} scp_state_s_t;

endpackage

// File: verilog/scp_top.sv
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "scp_params.svh"
module scp_top #(
	parameter int P_SHORT_DELAY_CYC =
		(`SCP_DELAY_SHORT_MS * `SCP_NS_PER_MS) / `SCP_SYS_CLK_PERIOD_NS,
	parameter int P_LONG_DELAY_CYC =
		(`SCP_DELAY_LONG_MS * `SCP_NS_PER_MS) / `SCP_SYS_CLK_PERIOD_NS,
	parameter int P_START_16K_CYC = `SCP_START_16K_CK
) (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	// Configuration bits
	input wire logic [3:0] I_CLOCK_SOURCE_SELECT_BITS,
	input wire logic [1:0] I_STARTUP_TIME_BITS,
	input wire logic I_INITIAL_DIVIDE_BY_EIGHT_BIT,
	input wire logic I_CLOCK_OUTPUT_ENABLE_BIT,
	input wire logic [7:0] I_FACTORY_TRIM,
	// Power management
	input wire logic I_POWER_DOWN,
	// Register port
	input wire logic [`SCP_ADDR_W-1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	// Divided clock enables and running status
	output logic O_CORE_CLOCK_EN,
	output logic O_PERIPHERAL_IO_CLOCK_EN,
	output logic O_CONVERTER_CLOCK_EN,
	output logic O_PROGRAM_MEMORY_CLOCK_EN,
	output logic O_SYS_RUNNING,
	// Clock output pin
	output logic O_CLOCK_OUTPUT_PIN,
	output logic O_CLOCK_OUTPUT_PIN_OE,
	// Oscillator control
	output logic [7:0] O_RC_OSCILLATOR_TRIM,
	output logic O_TRIM_RANGE_BIT,
	output logic O_CRYSTAL_MODE,
	output logic [1:0] O_CRYSTAL_RANGE
);

	scp_pkg::scp_state_s_t r_reg;
	scp_pkg::scp_state_s_t r_next;

	localparam logic [21:0] SHORT_CYC = 22'(P_SHORT_DELAY_CYC);
	localparam logic [21:0] LONG_CYC = 22'(P_LONG_DELAY_CYC);
	localparam logic [21:0] START_16K = 22'(P_START_16K_CYC);

	// ****************************************************************
	// Decoding functions
	// ****************************************************************
	function automatic logic is_crystal(input logic [3:0] sel);
		is_crystal = sel[3];
	endfunction

	// Wake time from power-down, in source clock cycles.
	function automatic logic [21:0] wake_cycles(input logic [3:0] sel, input logic [1:0] startup_time_bits);
		logic [2:0] key;
		key = {sel[0], startup_time_bits};
		if (!is_crystal(sel)) begin
			wake_cycles = `SCP_START_RC_CK;
		end else if (key <= 3'h1) begin
			wake_cycles = `SCP_START_258_CK;
		end else if (key <= 3'h4) begin
			wake_cycles = `SCP_START_1K_CK;
		end else begin
			wake_cycles = START_16K;
		end
	endfunction

	// Extra delay taken only on a reset, in source clock cycles.
	function automatic logic [21:0] reset_extra(input logic [3:0] sel, input logic [1:0] startup_time_bits);
		logic [21:0] ms_part;
		ms_part = 22'h000000;
		if (is_crystal(sel)) begin
			unique case ({sel[0], startup_time_bits})
				3'h0, 3'h3, 3'h6: ms_part = SHORT_CYC;
				3'h1, 3'h4, 3'h7: ms_part = LONG_CYC;
				default: ms_part = 22'h000000;
			endcase
		end else begin
			unique case (startup_time_bits)
				2'h0: ms_part = 22'h000000;
				2'h1: ms_part = SHORT_CYC;
				default: ms_part = LONG_CYC;
			endcase
		end
		reset_extra = `SCP_RESET_FIXED_CK + ms_part;
	endfunction

	// Codes above 1000 are reserved and behave as divide by 256.
	function automatic logic [7:0] div_mask(input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > `SCP_DIV_SEL_MAX) ? `SCP_DIV_SEL_MAX : sel;
		div_mask = 8'((9'h001 << s) - 9'h001);
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic [7:0] mask;
	logic [7:0] mask_after;
	logic period_end;
	logic out_allowed;

	always_comb begin
		r_next = r_reg;
		mask = div_mask(r_reg.div_sel);
		period_end = (r_reg.div_cnt == mask);
		mask_after = mask;
		out_allowed = I_CLOCK_OUTPUT_ENABLE_BIT && !is_crystal(I_CLOCK_SOURCE_SELECT_BITS);
		r_next.rdata = 8'h00;
		if (!I_NRST) begin
			r_next.state = scp_pkg::ST_STARTUP;
			r_next.start_cnt = wake_cycles(I_CLOCK_SOURCE_SELECT_BITS, I_STARTUP_TIME_BITS)
				+ reset_extra(I_CLOCK_SOURCE_SELECT_BITS, I_STARTUP_TIME_BITS);
			r_next.div_sel = I_INITIAL_DIVIDE_BY_EIGHT_BIT ?
				`SCP_DIV_SEL_DIV8 : `SCP_DIV_SEL_DIV1;
			r_next.new_sel = r_next.div_sel;
			r_next.pend = 1'b0;
			r_next.change_en = 1'b0;
			r_next.ce_timer = 3'h0;
			r_next.div_cnt = 8'h00;
			r_next.trim = I_FACTORY_TRIM;
			r_next.sys_tick = 1'b0;
			r_next.pin_level = 1'b0;
			r_next.pin_oe = 1'b0;
			r_next.running = 1'b0;
		end else begin
			// Change-enable window: rewriting it inside the window neither extends nor clears it.
			if (r_reg.change_en) begin
				r_next.ce_timer = r_reg.ce_timer - 3'h1;
				if (r_reg.ce_timer == 3'h1) begin
					r_next.change_en = 1'b0;
				end
			end
			if (I_WR) begin
				unique case (I_ADDR)
					`SCP_OFF_PRESCALE: begin
						if (!r_reg.change_en && I_WDATA == `SCP_CE_WRITE_VALUE) begin
							r_next.change_en = 1'b1;
							r_next.ce_timer = `SCP_CE_WINDOW;
						end else if (r_reg.change_en && !I_WDATA[`SCP_PRESCALE_CE_BIT]) begin
							r_next.new_sel = I_WDATA[3:0];
							r_next.pend = 1'b1;
							r_next.change_en = 1'b0;
							r_next.ce_timer = 3'h0;
						end
					end
					`SCP_OFF_TRIM: r_next.trim = I_WDATA;
					default: begin
					end
				endcase
			end
			if (I_RD) begin
				unique case (I_ADDR)
					// Software reads back the code it wrote, even while it waits for the end of
					// the current divided period; the divider count itself stays hidden.
					`SCP_OFF_PRESCALE: r_next.rdata = {r_reg.change_en, 3'h0, r_reg.new_sel};
					`SCP_OFF_TRIM: r_next.rdata = r_reg.trim;
					`SCP_OFF_STATUS: r_next.rdata = {3'h0, r_reg.pend, is_crystal(I_CLOCK_SOURCE_SELECT_BITS),
						I_CLOCK_SOURCE_SELECT_BITS[2:1], r_reg.running};
					default: r_next.rdata = 8'h00;
				endcase
			end
			r_next.sys_tick = 1'b0;
			unique case (r_reg.state)
				scp_pkg::ST_STARTUP: begin
					r_next.div_cnt = 8'h00;
					r_next.running = 1'b0;
					if (r_reg.pend) begin
						r_next.div_sel = r_reg.new_sel;
						r_next.pend = 1'b0;
					end
					if (r_reg.start_cnt <= 22'h000001) begin
						r_next.state = scp_pkg::ST_RUN;
						r_next.running = 1'b1;
					end else begin
						r_next.start_cnt = r_reg.start_cnt - 22'h000001;
					end
				end
				scp_pkg::ST_RUN: begin
					if (I_POWER_DOWN) begin
						r_next.state = scp_pkg::ST_POWER_DOWN;
						r_next.running = 1'b0;
						r_next.div_cnt = 8'h00;
					end else begin
						// The divider only restarts at the end of an old period, so no short
						// period can appear; the cost is up to one old period of latency.
						r_next.sys_tick = period_end;
						r_next.div_cnt = period_end ? 8'h00 : r_reg.div_cnt + 8'h01;
						if (period_end && r_reg.pend) begin
							r_next.div_sel = r_reg.new_sel;
							r_next.pend = 1'b0;
							mask_after = div_mask(r_reg.new_sel);
						end
					end
				end
				scp_pkg::ST_POWER_DOWN: begin
					if (!I_POWER_DOWN) begin
						r_next.state = scp_pkg::ST_STARTUP;
						r_next.start_cnt = wake_cycles(I_CLOCK_SOURCE_SELECT_BITS,
							I_STARTUP_TIME_BITS);
					end
				end
			endcase
			// High for the first half of each divided period, so the pin follows the
			// divided rate; at divide by one the pin stands high.
			r_next.pin_oe = out_allowed;
			r_next.pin_level = out_allowed && r_next.running &&
				(r_next.div_cnt <= (mask_after >> 1));
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		r_reg <= r_next;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign O_RDATA = r_reg.rdata;
	assign O_CORE_CLOCK_EN = r_reg.sys_tick;
	assign O_PERIPHERAL_IO_CLOCK_EN = r_reg.sys_tick;
	assign O_CONVERTER_CLOCK_EN = r_reg.sys_tick;
	assign O_PROGRAM_MEMORY_CLOCK_EN = r_reg.sys_tick;
	assign O_SYS_RUNNING = r_reg.running;
	assign O_CLOCK_OUTPUT_PIN = r_reg.pin_level;
	assign O_CLOCK_OUTPUT_PIN_OE = r_reg.pin_oe;
	assign O_RC_OSCILLATOR_TRIM = r_reg.trim;
	assign O_TRIM_RANGE_BIT = r_reg.trim[`SCP_TRIM_RANGE_BIT];

	// Crystal range is the upper select bits; 00 means 0.4-0.9 MHz.
	logic xtal_mode_reg;
	logic [1:0] xtal_range_reg;
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			xtal_mode_reg <= 1'b0;
			xtal_range_reg <= 2'h0;
		end else begin
			xtal_mode_reg <= is_crystal(I_CLOCK_SOURCE_SELECT_BITS);
			xtal_range_reg <= I_CLOCK_SOURCE_SELECT_BITS[2:1];
		end
	end
	assign O_CRYSTAL_MODE = xtal_mode_reg;
	assign O_CRYSTAL_RANGE = xtal_range_reg;

endmodule

// File: sim/scp_top_properties.sv
`timescale 1ns/1ps
`include "scp_params.svh"
module scp_top_properties (
	// Clock, reset and inputs
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	input wire logic [3:0] I_CLOCK_SOURCE_SELECT_BITS,
	input wire logic I_CLOCK_OUTPUT_ENABLE_BIT,
	input wire logic [`SCP_ADDR_W-1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	// Outputs
	input wire logic [7:0] O_RDATA,
	input wire logic O_CORE_CLOCK_EN,
	input wire logic O_PERIPHERAL_IO_CLOCK_EN,
	input wire logic O_CONVERTER_CLOCK_EN,
	input wire logic O_PROGRAM_MEMORY_CLOCK_EN,
	input wire logic O_SYS_RUNNING,
	input wire logic O_CLOCK_OUTPUT_PIN_OE,
	input wire logic [7:0] O_RC_OSCILLATOR_TRIM,
	input wire logic O_TRIM_RANGE_BIT,
	input wire logic O_CRYSTAL_MODE,
	input wire logic [1:0] O_CRYSTAL_RANGE
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);
	property p_same_en;
		O_CORE_CLOCK_EN == O_PERIPHERAL_IO_CLOCK_EN && O_CORE_CLOCK_EN == O_CONVERTER_CLOCK_EN
			&& O_CORE_CLOCK_EN == O_PROGRAM_MEMORY_CLOCK_EN;
	endproperty
	a_same_en: assert property (p_same_en)
		else $error("divided clock enables differ");
	property p_gated;
		!O_SYS_RUNNING && !$past(O_SYS_RUNNING) |-> !O_CORE_CLOCK_EN;
	endproperty
	a_gated: assert property (p_gated)
		else $error("tick while not running");
	property p_no_xtal_out;
		O_CRYSTAL_MODE |-> !O_CLOCK_OUTPUT_PIN_OE;
	endproperty
	a_no_xtal_out: assert property (p_no_xtal_out)
		else $error("clock output with crystal");
	// Reset itself is the cause here, so this one must not be disabled by it.
	property p_rst_quiet;
		disable iff (1'b0) !I_NRST |=> !O_CLOCK_OUTPUT_PIN_OE;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("clock output during reset");
	property p_out_on;
		I_CLOCK_OUTPUT_ENABLE_BIT && !I_CLOCK_SOURCE_SELECT_BITS[3] |=> O_CLOCK_OUTPUT_PIN_OE;
	endproperty
	a_out_on: assert property (p_out_on)
		else $error("clock output not enabled");
	property p_xtal_range;
		I_CLOCK_SOURCE_SELECT_BITS[3] |=> O_CRYSTAL_MODE
			&& O_CRYSTAL_RANGE == $past(I_CLOCK_SOURCE_SELECT_BITS[2:1]);
	endproperty
	a_xtal_range: assert property (p_xtal_range)
		else $error("crystal range wrong");
	property p_trim_wr;
		I_WR && I_ADDR == `SCP_OFF_TRIM |=> O_RC_OSCILLATOR_TRIM == $past(I_WDATA);
	endproperty
	a_trim_wr: assert property (p_trim_wr)
		else $error("trim write lost");
	property p_range_bit;
		O_TRIM_RANGE_BIT == O_RC_OSCILLATOR_TRIM[7];
	endproperty
	a_range_bit: assert property (p_range_bit)
		else $error("range bit differs from trim");
	property p_rdata_idle;
		!$past(I_RD) |-> O_RDATA == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read slot");
endmodule
bind scp_top scp_top_properties u_props (.I_SYS_CLK, .I_NRST, .I_CLOCK_SOURCE_SELECT_BITS,
	.I_CLOCK_OUTPUT_ENABLE_BIT, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_CORE_CLOCK_EN,
	.O_PERIPHERAL_IO_CLOCK_EN, .O_CONVERTER_CLOCK_EN, .O_PROGRAM_MEMORY_CLOCK_EN,
	.O_SYS_RUNNING, .O_CLOCK_OUTPUT_PIN_OE, .O_RC_OSCILLATOR_TRIM, .O_TRIM_RANGE_BIT,
	.O_CRYSTAL_MODE, .O_CRYSTAL_RANGE);

// File: sim/scp_clk_sink.sv
`timescale 1ns/1ps
// A circuit fed from the clock output pin; a released pin counts as low.
module scp_clk_sink (
	input wire logic i_clk,
	input wire logic i_pin,
	input wire logic i_oe,
	output logic [15:0] o_edges
);
	logic prev = 1'b0;
	initial o_edges = 16'h0000;
	always @(posedge i_clk) begin
		prev <= i_pin & i_oe;
		if ((i_pin & i_oe) && !prev) begin
			o_edges <= o_edges + 16'h0001;
		end
	end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "scp_params.svh"
module testbench;
	logic clk, nrst, d8, cko, pd, wr, rd, run, pin, oe, rng, xm, en;
	logic [3:0] sel;
	logic [1:0] startup_time_bits, addr, xr;
	logic [7:0] ftrim, wdata, rdata, trim, r;
	logic [15:0] edges, e0;
	int fail_count = 0;
	int n_checks = 0;
	int g, n;
	scp_top #(.P_SHORT_DELAY_CYC(20), .P_LONG_DELAY_CYC(40), .P_START_16K_CYC(30)) dut (
		.I_SYS_CLK(clk), .I_NRST(nrst), .I_CLOCK_SOURCE_SELECT_BITS(sel),
		.I_STARTUP_TIME_BITS(startup_time_bits), .I_INITIAL_DIVIDE_BY_EIGHT_BIT(d8),
		.I_CLOCK_OUTPUT_ENABLE_BIT(cko), .I_FACTORY_TRIM(ftrim), .I_POWER_DOWN(pd),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.O_CORE_CLOCK_EN(en), .O_PERIPHERAL_IO_CLOCK_EN(), .O_CONVERTER_CLOCK_EN(),
		.O_PROGRAM_MEMORY_CLOCK_EN(), .O_SYS_RUNNING(run), .O_CLOCK_OUTPUT_PIN(pin),
		.O_CLOCK_OUTPUT_PIN_OE(oe), .O_RC_OSCILLATOR_TRIM(trim), .O_TRIM_RANGE_BIT(rng),
		.O_CRYSTAL_MODE(xm), .O_CRYSTAL_RANGE(xr));
	scp_clk_sink sink (.i_clk(clk), .i_pin(pin), .i_oe(oe), .o_edges(edges));
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Each access leaves one idle cycle so no strobe is assigned twice in a time step.
	task automatic wreg(input logic [1:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [1:0] a);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		r = rdata;
	endtask
	task automatic set_div(input logic [3:0] c);
		wreg(`SCP_OFF_PRESCALE, `SCP_CE_WRITE_VALUE);
		wreg(`SCP_OFF_PRESCALE, {4'h0, c});
	endtask
	// Cycles from one divided tick to the next; bounded so a dead divider cannot hang.
	task automatic gap(output int k);
		for (int i = 0; i < 600 && !en; i++) @(posedge clk);
		@(posedge clk);
		for (k = 1; k < 600 && !en; k++) @(posedge clk);
	endtask
	task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic d, input int e);
		sel <= s;
		startup_time_bits <= t;
		d8 <= d;
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		chk(oe, 1'b0);
		chk(trim, ftrim);
		nrst <= 1'b1;
		for (n = 0; n < 2000 && !run; n++) @(posedge clk);
		chk(n >= e - 2 && n <= e + 3, 1'b1);
		rreg(`SCP_OFF_PRESCALE);
		chk(r, d ? `SCP_DIV_SEL_DIV8 : `SCP_DIV_SEL_DIV1);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#(50 * 20000);
		fail_count++;
		results();
	end
	initial begin
		{nrst, wr, rd, pd, addr, wdata} <= '0;
		{sel, startup_time_bits, d8, cko, ftrim} <= {4'h2, 2'h2, 1'b1, 1'b1, 8'h6F};
		@(posedge clk);
		do_reset(4'h2, 2'h2, 1'b1, 60);
		gap(g);
		chk(g, 8);
		wreg(`SCP_OFF_PRESCALE, 8'h01);
		wreg(`SCP_OFF_PRESCALE, `SCP_CE_WRITE_VALUE);
		repeat (5) @(posedge clk);
		wreg(`SCP_OFF_PRESCALE, 8'h01);
		rreg(`SCP_OFF_PRESCALE);
		chk(r, 8'h03);
		for (int c = 0; c < 10; c++) begin
			set_div(c[3:0]);
			rreg(`SCP_OFF_PRESCALE);
			chk(r, c);
			gap(g);
			gap(g);
			chk(g, 1 << (c > 8 ? 8 : c));
		end
		set_div(4'h2);
		gap(g);
		e0 = edges;
		repeat (40) @(posedge clk);
		chk(edges - e0, 10);
		wreg(`SCP_OFF_TRIM, 8'h7F);
		rreg(`SCP_OFF_TRIM);
		chk({rng, r}, 9'h07F);
		wreg(`SCP_OFF_TRIM, 8'h80);
		chk({rng, trim}, 9'h180);
		wreg(2'h3, 8'hFF);
		rreg(2'h3);
		chk(r, 8'h00);
		pd <= 1'b1;
		repeat (3) @(posedge clk);
		chk(run, 1'b0);
		pd <= 1'b0;
		for (n = 0; n < 50 && !run; n++) @(posedge clk);
		chk(n >= 4 && n <= 9, 1'b1);
		for (int c = 8; c < 16; c++) begin
			sel <= c[3:0];
			repeat (2) @(posedge clk);
			chk({xm, xr, oe}, {1'b1, c[2:1], 1'b0});
		end
		do_reset(4'h9, 2'h1, 1'b0, 44);
		do_reset(4'h8, 2'h0, 1'b0, 292);
		results();
	end
endmodule
